// file: verilog/sep_system_event_probe.sv
// System event probe: windowed event counter with combining modes
`timescale 1ns/10ps
`default_nettype none
module sep_system_event_probe (
    input wire logic i_system_clock, // System clock, 50 MHz
    input wire logic i_arst_n, // Asynchronous reset, active low
    input wire logic i_probe_arm, // Arm pulse
    input wire logic i_probe_reset, // Probe soft reset pulse
    input wire logic i_result_read, // Pulse when software reads the result
    input wire logic [1:0] i_combine_mode, // Combining mode
    input wire logic i_wrap_count, // 1: counts roll over, 0: stick at max
    input wire logic [21:0] i_close_event_limit, // Closing events per run
    input wire logic [5:0] i_sync_event_select, // Sync event code
    input wire logic [1:0] i_sync_func, // Sync event function
    input wire logic [5:0] i_window_open_select, // Opening event code
    input wire logic [1:0] i_open_func, // Opening event function
    input wire logic [5:0] i_window_close_select, // Closing event code
    input wire logic [1:0] i_close_func, // Closing event function
    input wire logic [5:0] i_counted_event_select, // Target event code
    input wire logic [1:0] i_counted_func, // Target event function
    input wire logic [3:0] i_aux_sequencer_out, // Auxiliary sequencer outputs
    input wire logic i_selected_trigger, // Selected trigger
    input wire logic i_selected_phase_a, // Encoder phase A
    input wire logic i_selected_phase_b, // Encoder phase B
    input wire logic i_quadrature_out, // Quadrature decoder output
    input wire logic i_encoder_divider_out, // Encoder divider output
    input wire logic i_system_irq, // Channel system interrupt
    input wire logic i_host_sent, // One pulse per chunk sent
    input wire logic i_host_dropped, // One pulse per chunk dropped
    input wire logic i_host_busy, // Host-bound path busy
    input wire logic [2:0] i_link_clock, // Link pixel clocks base/med/full
    input wire logic [2:0] i_link_lock, // Receiver lock base/med/full
    input wire logic [2:0] i_frame_valid, // Frame valid base/med/full
    input wire logic [2:0] i_line_valid, // Line valid base/med/full
    input wire logic [2:0] i_data_valid, // Data valid base/med/full
    input wire logic [3:0] i_camera_control, // Camera control lines 1 to 4
    output logic [23:0] o_probe_result, // Combined result
    output logic o_probe_busy, // Probe busy
    output logic o_result_updated_flag // Result updated since last read
);
    // Link-side pins, two-stage synchroniser
    logic [18:0] link_meta;
    logic [18:0] link_sync;
    logic [18:0] next_link_meta;
    logic [18:0] link_raw;

    // Internal 100 ns time base
    logic [7:0] tick_count;
    logic [7:0] next_tick_count;
    logic tick_pulse;
    logic next_tick_pulse;

    logic [63:0] sources;
    logic fire_sync;
    logic fire_open;
    logic fire_close;
    logic fire_count;

    sep_pkg::sep_state_t state;
    sep_pkg::sep_state_t next_state;
    logic [23:0] capture;
    logic [23:0] next_capture;
    logic [23:0] result;
    logic [23:0] next_result;
    logic [21:0] closes;
    logic [21:0] next_closes;
    logic first_done;
    logic next_first_done;
    logic busy;
    logic next_busy;
    logic updated;
    logic next_updated;

    logic [23:0] capture_final;
    logic [24:0] sum_wide;
    logic [23:0] sum_value;
    logic [21:0] closes_inc;
    logic limit_hit;

    always_comb begin
        link_raw = {i_camera_control, i_data_valid, i_line_valid, i_frame_valid,
                    i_link_lock, i_link_clock};
        next_link_meta = link_raw;
    end

    always_ff @(posedge i_system_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            link_meta <= 19'h00000;
            link_sync <= 19'h00000;
        end else begin
            link_meta <= next_link_meta;
            link_sync <= link_meta;
        end
    end

    always_comb begin
        if (tick_count == sep_pkg::TICK_LAST) begin
            next_tick_count = sep_pkg::TICK_RESET;
            next_tick_pulse = 1'b1;
        end else begin
            next_tick_count = tick_count + 8'h01;
            next_tick_pulse = 1'b0;
        end
    end

    always_ff @(posedge i_system_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            tick_count <= sep_pkg::TICK_RESET;
            tick_pulse <= 1'b0;
        end else begin
            tick_count <= next_tick_count;
            tick_pulse <= next_tick_pulse;
        end
    end

    // common event map for all four selectors
    always_comb begin
        // unlisted and zero codes stay low, so they fire only with the level-low function
        sources = 64'h0000000000000000;
        sources[sep_pkg::EVENT_EVERY_CYCLE] = 1'b1;
        sources[sep_pkg::EVENT_SYSTEM_CLOCK] = 1'b1;
        sources[sep_pkg::EVENT_TENTH_MICROSECOND] = tick_pulse;
        sources[sep_pkg::EVENT_AUX_SEQUENCER +: 4] = i_aux_sequencer_out;
        sources[sep_pkg::EVENT_TRIGGER] = i_selected_trigger;
        sources[sep_pkg::EVENT_PHASE_A] = i_selected_phase_a;
        sources[sep_pkg::EVENT_PHASE_B] = i_selected_phase_b;
        sources[sep_pkg::EVENT_QUADRATURE] = i_quadrature_out;
        sources[sep_pkg::EVENT_ENCODER_DIVIDER] = i_encoder_divider_out;
        sources[sep_pkg::EVENT_SYSTEM_IRQ] = i_system_irq;
        sources[sep_pkg::EVENT_HOST_SENT] = i_host_sent;
        sources[sep_pkg::EVENT_HOST_DROPPED] = i_host_dropped;
        sources[sep_pkg::EVENT_HOST_BUSY] = i_host_busy;
        sources[sep_pkg::EVENT_LINK_CLOCK_BASE +: 3] = link_sync[2:0];
        sources[sep_pkg::EVENT_LOCK_BASE +: 3] = link_sync[5:3];
        sources[sep_pkg::EVENT_FRAME_BASE +: 3] = link_sync[8:6];
        sources[sep_pkg::EVENT_LINE_BASE +: 3] = link_sync[11:9];
        sources[sep_pkg::EVENT_DATA_BASE +: 3] = link_sync[14:12];
        sources[sep_pkg::EVENT_CONTROL_LINE1 +: 4] = link_sync[18:15];
    end

    sep_event_detect u_sync_detect (
        .i_system_clock(i_system_clock), .i_arst_n(i_arst_n), .i_sources(sources),
        .i_select(i_sync_event_select), .i_func(i_sync_func), .o_fire(fire_sync)
    );

    sep_event_detect u_open_detect (
        .i_system_clock(i_system_clock), .i_arst_n(i_arst_n), .i_sources(sources),
        .i_select(i_window_open_select), .i_func(i_open_func), .o_fire(fire_open)
    );

    sep_event_detect u_close_detect (
        .i_system_clock(i_system_clock), .i_arst_n(i_arst_n), .i_sources(sources),
        .i_select(i_window_close_select), .i_func(i_close_func), .o_fire(fire_close)
    );

    sep_event_detect u_count_detect (
        .i_system_clock(i_system_clock), .i_arst_n(i_arst_n), .i_sources(sources),
        .i_select(i_counted_event_select), .i_func(i_counted_func), .o_fire(fire_count)
    );

    // Capture count including a target that fires with the close
    always_comb begin
        capture_final = capture;
        if (fire_count) begin
            if (capture != sep_pkg::RESULT_MAX) begin
                capture_final = capture + 24'h000001;
            end else if (i_wrap_count) begin
                capture_final = sep_pkg::RESULT_RESET;
            end
        end
        sum_wide = {1'b0, result} + {1'b0, capture_final};
        if (sum_wide[24] && !i_wrap_count) begin
            sum_value = sep_pkg::RESULT_MAX;
        end else begin
            sum_value = sum_wide[23:0];
        end
        closes_inc = closes + 22'h000001;
        limit_hit = (closes_inc >= i_close_event_limit);
    end

    always_comb begin
        next_state = state;
        next_capture = capture;
        next_result = result;
        next_closes = closes;
        next_first_done = first_done;
        next_busy = busy;
        next_updated = updated;
        // read clears, a same-cycle update wins below
        if (i_result_read) begin
            next_updated = 1'b0;
        end
        case (state)
            sep_pkg::SEP_IDLE: begin
                if (i_probe_arm) begin
                    next_state = sep_pkg::SEP_SYNC_WAIT;
                    next_busy = 1'b1;
                    next_result = sep_pkg::RESULT_RESET;
                    next_capture = sep_pkg::RESULT_RESET;
                    next_closes = sep_pkg::CLOSES_RESET;
                    next_first_done = 1'b0;
                end
            end
            sep_pkg::SEP_SYNC_WAIT: begin
                if (fire_sync) begin
                    next_state = sep_pkg::SEP_OPEN_WAIT;
                end
            end
            sep_pkg::SEP_OPEN_WAIT: begin
                // window opens on the opening event
                if (fire_open) begin
                    next_state = sep_pkg::SEP_COUNTING;
                    next_capture = sep_pkg::RESULT_RESET;
                end
            end
            sep_pkg::SEP_COUNTING: begin
                next_capture = capture_final;
                if (fire_close) begin
                    next_closes = closes_inc;
                    next_first_done = 1'b1;
                    next_updated = 1'b1;
                    case (i_combine_mode)
                        sep_pkg::COMBINE_LATEST: next_result = capture_final;
                        sep_pkg::COMBINE_SUM: next_result = sum_value;
                        sep_pkg::COMBINE_SMALLEST: begin
                            if (!first_done || (capture_final < result)) begin
                                next_result = capture_final;
                            end
                        end
                        sep_pkg::COMBINE_LARGEST: begin
                            if (!first_done || (capture_final > result)) begin
                                next_result = capture_final;
                            end
                        end
                        default: next_result = result;
                    endcase
                    if (limit_hit) begin
                        next_state = sep_pkg::SEP_IDLE;
                        next_busy = 1'b0;
                    end else begin
                        next_state = sep_pkg::SEP_OPEN_WAIT;
                    end
                end
            end
            default: begin
                next_state = sep_pkg::SEP_IDLE;
                next_busy = 1'b0;
            end
        endcase
        // Soft reset aborts everything
        if (i_probe_reset) begin
            next_state = sep_pkg::SEP_IDLE;
            next_busy = 1'b0;
            next_result = sep_pkg::RESULT_RESET;
            next_capture = sep_pkg::RESULT_RESET;
            next_closes = sep_pkg::CLOSES_RESET;
            next_first_done = 1'b0;
            next_updated = 1'b0;
        end
    end

    always_ff @(posedge i_system_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state <= sep_pkg::SEP_IDLE;
            capture <= sep_pkg::RESULT_RESET;
            result <= sep_pkg::RESULT_RESET;
            closes <= sep_pkg::CLOSES_RESET;
            first_done <= 1'b0;
            busy <= 1'b0;
            updated <= 1'b0;
        end else begin
            state <= next_state;
            capture <= next_capture;
            result <= next_result;
            closes <= next_closes;
            first_done <= next_first_done;
            busy <= next_busy;
            updated <= next_updated;
        end
    end

    // result stays stable while idle, until an arm or a soft reset clears it
    always_comb begin
        o_probe_result = result;
        o_probe_busy = busy;
        o_result_updated_flag = updated;
    end
endmodule : sep_system_event_probe
`default_nettype wire

// file: verilog/sep_pkg.sv
// Constants shared by the event probe and its event detector
package sep_pkg;
    // Widths
    localparam int SEL_W = 6;
    localparam int FUNC_W = 2;
    localparam int MODE_W = 2;
    localparam int RESULT_W = 24;
    localparam int LIMIT_W = 22;
    localparam int SRC_N = 64;
    localparam int AUX_N = 4;
    localparam int LINK_N = 3;
    localparam int CC_N = 4;
    localparam int LINK_SYNC_N = 19;

    // Event codes
    localparam logic [5:0] EVENT_NONE = 6'h00;
    localparam logic [5:0] EVENT_EVERY_CYCLE = 6'h01;
    localparam logic [5:0] EVENT_SYSTEM_CLOCK = 6'h02;
    localparam logic [5:0] EVENT_TENTH_MICROSECOND = 6'h03;
    localparam logic [5:0] EVENT_AUX_SEQUENCER = 6'h04;
    localparam logic [5:0] EVENT_TRIGGER = 6'h08;
    localparam logic [5:0] EVENT_PHASE_A = 6'h09;
    localparam logic [5:0] EVENT_PHASE_B = 6'h0A;
    localparam logic [5:0] EVENT_QUADRATURE = 6'h0B;
    localparam logic [5:0] EVENT_ENCODER_DIVIDER = 6'h0C;
    localparam logic [5:0] EVENT_SYSTEM_IRQ = 6'h0F;
    localparam logic [5:0] EVENT_HOST_SENT = 6'h10;
    localparam logic [5:0] EVENT_HOST_DROPPED = 6'h11;
    localparam logic [5:0] EVENT_HOST_BUSY = 6'h12;
    localparam logic [5:0] EVENT_LINK_CLOCK_BASE = 6'h20;
    localparam logic [5:0] EVENT_LOCK_BASE = 6'h23;
    localparam logic [5:0] EVENT_FRAME_BASE = 6'h26;
    localparam logic [5:0] EVENT_LINE_BASE = 6'h29;
    localparam logic [5:0] EVENT_DATA_BASE = 6'h2C;
    localparam logic [5:0] EVENT_CONTROL_LINE1 = 6'h2F;

    // Event functions
    localparam logic [1:0] FUNC_RISING = 2'h0;
    localparam logic [1:0] FUNC_FALLING = 2'h1;
    localparam logic [1:0] FUNC_LEVEL_HIGH = 2'h2;
    localparam logic [1:0] FUNC_LEVEL_LOW = 2'h3;

    // Combining modes
    localparam logic [1:0] COMBINE_LATEST = 2'h0;
    localparam logic [1:0] COMBINE_SUM = 2'h1;
    localparam logic [1:0] COMBINE_SMALLEST = 2'h2;
    localparam logic [1:0] COMBINE_LARGEST = 2'h3;

    // Reset and maximum values
    localparam logic [23:0] RESULT_RESET = 24'h000000;
    localparam logic [23:0] RESULT_MAX = 24'hFFFFFF;
    localparam logic [21:0] CLOSES_RESET = 22'h000000;

    // Timing
    localparam int SYSTEM_CLOCK_HZ = 50000000;
    localparam int TICK_PERIOD_NS = 100;
    localparam int TICK_CYCLES_RAW = (TICK_PERIOD_NS * (SYSTEM_CLOCK_HZ / 1000000)) / 1000;
    localparam int TICK_CYCLES = (TICK_CYCLES_RAW < 1) ? 1 : TICK_CYCLES_RAW;
    localparam int TICK_W = 8;
    localparam logic [7:0] TICK_LAST = 8'(TICK_CYCLES - 1);
    localparam logic [7:0] TICK_RESET = 8'h00;

    typedef enum logic [3:0] {
        SEP_IDLE = 4'b0001,
        SEP_SYNC_WAIT = 4'b0010,
        SEP_OPEN_WAIT = 4'b0100,
        SEP_COUNTING = 4'b1000
    } sep_state_t;
endpackage : sep_pkg

// file: verilog/sep_event_detect.sv
// Event selector with rising, falling, high or low qualification for all codes except 1 and 2, which fire every cycle
`timescale 1ns/10ps
`default_nettype none
module sep_event_detect (
    input wire logic i_system_clock, // System clock
    input wire logic i_arst_n, // Asynchronous reset, active low
    input wire logic [63:0] i_sources, // Event sources indexed by code
    input wire logic [5:0] i_select, // Event code
    input wire logic [1:0] i_func, // Qualifying function
    output logic o_fire // Event fires this cycle
);
    logic level;
    logic prev;
    logic next_prev;

    always_comb begin
        level = i_sources[i_select];
        next_prev = level;
        if ((i_select == sep_pkg::EVENT_EVERY_CYCLE) ||
            (i_select == sep_pkg::EVENT_SYSTEM_CLOCK)) begin
            o_fire = 1'b1;
        end else begin
            case (i_func)
                sep_pkg::FUNC_RISING: o_fire = level & ~prev;
                sep_pkg::FUNC_FALLING: o_fire = ~level & prev;
                sep_pkg::FUNC_LEVEL_HIGH: o_fire = level;
                sep_pkg::FUNC_LEVEL_LOW: o_fire = ~level;
                default: o_fire = 1'b0;
            endcase
        end
    end

    always_ff @(posedge i_system_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            prev <= 1'b0;
        end else begin
            prev <= next_prev;
        end
    end
endmodule : sep_event_detect
`default_nettype wire

// file: test/sep_probe_properties.sv
// Port-level properties of the system event probe
`timescale 1ns/10ps
`default_nettype none
module sep_probe_properties (
    input wire logic i_system_clock, // System clock
    input wire logic i_arst_n, // Async reset, active low
    input wire logic i_probe_arm, // Arm pulse
    input wire logic i_probe_reset, // Soft reset pulse
    input wire logic i_result_read, // Result read pulse
    input wire logic [5:0] i_window_close_select, // Closing event code
    input wire logic [23:0] o_probe_result, // Combined result
    input wire logic o_probe_busy, // Busy
    input wire logic o_result_updated_flag // Updated flag
);
    default clocking @(posedge i_system_clock); endclocking
    default disable iff (!i_arst_n);
    property p_arm_busy;
        i_probe_arm && !o_probe_busy && !i_probe_reset |=> o_probe_busy && o_probe_result == sep_pkg::RESULT_RESET;
    endproperty
    a_arm_busy: assert property (p_arm_busy) else $error("arm not taken");
    property p_soft_reset;
        i_probe_reset |=> !o_probe_busy && !o_result_updated_flag && o_probe_result == sep_pkg::RESULT_RESET;
    endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("soft reset not idle");
    property p_done_flag;
        $fell(o_probe_busy) && !$past(i_probe_reset) |-> o_result_updated_flag;
    endproperty
    a_done_flag: assert property (p_done_flag) else $error("finish without update");
    property p_result_hold;
        !o_probe_busy && !$past(o_probe_busy) && !$past(i_probe_arm) && !$past(i_probe_reset) |-> $stable(o_probe_result);
    endproperty
    a_result_hold: assert property (p_result_hold) else $error("idle result moved");
    property p_flag_clear;
        i_result_read && !o_probe_busy |=> !o_result_updated_flag;
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");
    property p_flag_hold;
        o_result_updated_flag && !i_result_read && !i_probe_reset && !i_probe_arm |=> o_result_updated_flag;
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag dropped");
    property p_flag_cause;
        $rose(o_result_updated_flag) |-> $past(o_probe_busy);
    endproperty
    a_flag_cause: assert property (p_flag_cause) else $error("flag set while idle");
    property p_close_never;
        o_probe_busy && i_window_close_select == sep_pkg::EVENT_NONE && !i_probe_reset |=> o_probe_busy && $stable(o_probe_result);
    endproperty
    a_close_never: assert property (p_close_never) else $error("never code fired");
    property p_busy_drop;
        o_probe_busy && !i_probe_reset |=> o_probe_busy || o_result_updated_flag;
    endproperty
    a_busy_drop: assert property (p_busy_drop) else $error("busy fell without update");
endmodule : sep_probe_properties
bind sep_system_event_probe sep_probe_properties chk_u (.i_system_clock, .i_arst_n, .i_probe_arm,
    .i_probe_reset, .i_result_read, .i_window_close_select, .o_probe_result, .o_probe_busy,
    .o_result_updated_flag);
`default_nettype wire

// file: test/sep_event_source_model.sv
// Board event sources: steady levels plus frame and line patterns
`timescale 1ns/10ps
`default_nettype none
module sep_event_source_model (
    input wire logic i_system_clock, // System clock
    input wire logic i_arst_n, // Async reset, active low
    input wire logic i_level, // Level of all steady sources
    output logic [3:0] o_aux, // Sequencer outputs
    output logic [8:0] o_misc, // Trigger, encoder, irq and host sources
    output logic [2:0] o_link_clock, // Link pixel clocks
    output logic [2:0] o_link_lock, // Receiver lock
    output logic [2:0] o_frame_valid, // Frame valid, base patterned
    output logic [2:0] o_line_valid, // Line valid, base patterned
    output logic [2:0] o_data_valid, // Data valid
    output logic [3:0] o_camera_control // Control lines
);
    logic [4:0] frame_cnt;
    logic [4:0] line_cnt;
    logic [1:0] line_idx;
    logic [4:0] line_len;
    // Lines of 4, 8 and 12 cycles in turn, gap of 6
    assign line_len = {1'b0, line_idx, 2'b00} + 5'h04;
    always_ff @(posedge i_system_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            frame_cnt <= 5'h00;
            line_cnt <= 5'h00;
            line_idx <= 2'h0;
        end else begin
            frame_cnt <= (frame_cnt == 5'h13) ? 5'h00 : frame_cnt + 5'h01;
            if (line_cnt == line_len + 5'h05) begin
                line_cnt <= 5'h00;
                line_idx <= (line_idx == 2'h2) ? 2'h0 : line_idx + 2'h1;
            end else begin
                line_cnt <= line_cnt + 5'h01;
            end
        end
    end
    // Frames of 10 cycles high in every 20
    assign o_frame_valid = {{2{i_level}}, frame_cnt < 5'h0A};
    assign o_line_valid = {{2{i_level}}, line_cnt < line_len};
    assign o_aux = {4{i_level}};
    assign o_misc = {9{i_level}};
    assign o_link_clock = {3{i_level}};
    assign o_link_lock = {3{i_level}};
    assign o_data_valid = {3{i_level}};
    assign o_camera_control = {4{i_level}};
endmodule : sep_event_source_model
`default_nettype wire

// file: test/testbench.sv
// Self-checking bench for the system event probe
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic i_system_clock = 1'b0;
    logic i_arst_n = 1'b0;
    logic arm = 1'b0;
    logic prst = 1'b0;
    logic rd = 1'b0;
    logic lvl = 1'b1;
    logic [1:0] mode = 2'h1;
    logic [1:0] tf = 2'h2;
    logic [21:0] lim = 22'h000001;
    logic [5:0] ss = 6'h01;
    logic [5:0] os = 6'h26;
    logic [5:0] cs = 6'h26;
    logic [5:0] ts = 6'h01;
    logic [3:0] aux;
    logic [3:0] cc;
    logic [8:0] misc;
    logic [2:0] lclk;
    logic [2:0] lock;
    logic [2:0] fv;
    logic [2:0] lv;
    logic [2:0] dav;
    logic [23:0] res;
    logic busy;
    logic flag;
    int n_errors = 0;
    int n_tests = 0;
    int c;
    int p;
    int m;

    initial begin
        forever #10 i_system_clock = ~i_system_clock;
    end

    sep_event_source_model src_u (.i_system_clock(i_system_clock), .i_arst_n(i_arst_n), .i_level(lvl),
        .o_aux(aux), .o_misc(misc), .o_link_clock(lclk), .o_link_lock(lock), .o_frame_valid(fv),
        .o_line_valid(lv), .o_data_valid(dav), .o_camera_control(cc));

    sep_system_event_probe dut_u (.i_system_clock(i_system_clock), .i_arst_n(i_arst_n),
        .i_probe_arm(arm), .i_probe_reset(prst), .i_result_read(rd), .i_combine_mode(mode),
        .i_wrap_count(1'b0), .i_close_event_limit(lim), .i_sync_event_select(ss),
        .i_sync_func(2'h0), .i_window_open_select(os), .i_open_func(2'h0),
        .i_window_close_select(cs), .i_close_func(2'h1), .i_counted_event_select(ts),
        .i_counted_func(tf), .i_aux_sequencer_out(aux), .i_selected_trigger(misc[0]),
        .i_selected_phase_a(misc[1]), .i_selected_phase_b(misc[2]), .i_quadrature_out(misc[3]),
        .i_encoder_divider_out(misc[4]), .i_system_irq(misc[5]), .i_host_sent(misc[6]),
        .i_host_dropped(misc[7]), .i_host_busy(misc[8]), .i_link_clock(lclk), .i_link_lock(lock),
        .i_frame_valid(fv), .i_line_valid(lv), .i_data_valid(dav), .i_camera_control(cc),
        .o_probe_result(res), .o_probe_busy(busy), .o_result_updated_flag(flag));

    function automatic logic listed(input int k);
        return k == 1 || k == 2 || (k >= 4 && k <= 12) || (k >= 15 && k <= 18) || (k >= 32 && k <= 50);
    endfunction : listed

    task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic pulse(ref logic s);
        @(posedge i_system_clock);
        #2 s = 1'b1;
        @(posedge i_system_clock);
        #2 s = 1'b0;
    endtask : pulse

    task automatic run(input logic [5:0] t, input logic [1:0] f, input logic [21:0] l,
                       input logic [1:0] md);
        int i;
        ts = t;
        tf = f;
        lim = l;
        mode = md;
        pulse(arm);
        i = 0;
        while (busy !== 1'b0 && i < 500) begin
            @(posedge i_system_clock);
            #2;
            i++;
        end
        check("busy after run", {23'h000000, busy}, 24'h000000);
    endtask : run

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : summarize

    initial begin
        #1000000;
        n_errors++;
        summarize();
    end

    initial begin
        repeat (2) @(posedge i_system_clock);
        #2 i_arst_n = 1'b1;
        // Codes 0 to 51 except 3, 38 and 41 as target inside a 10-cycle frame window, high function, then low function on listed codes only
        for (p = 0; p < 2; p++) begin
            lvl = (p == 0);
            repeat (4) @(posedge i_system_clock);
            for (c = 0; c < 52; c++) begin
                if (c != 3 && c != 38 && c != 41 && (p == 0 || listed(c))) begin
                    run(6'(c), p == 0 ? 2'h2 : 2'h3, 22'h000001, 2'h1);
                    check("event count", res, listed(c) ? 24'h00000A : 24'h000000);
                end
            end
        end
        $display("event code test done");
        run(6'h03, 2'h0, 22'h000001, 2'h1);
        check("tick count", res, 24'h000002);
        run(6'h01, 2'h2, 22'h000003, 2'h0);
        check("latest of three", res, 24'h00000A);
        check("updated flag", {23'h000000, flag}, 24'h000001);
        pulse(rd);
        check("flag after read", {23'h000000, flag}, 24'h000000);
        check("result after read", res, 24'h00000A);
        $display("timing and flag test done");
        os = 6'h29;
        cs = 6'h29;
        for (m = 1; m < 4; m++) begin
            run(6'h01, 2'h2, 22'h000003, 2'(m));
            check("combined lines", res, m == 1 ? 24'h000018 : (m == 2 ? 24'h000004 : 24'h00000C));
        end
        pulse(prst);
        check("flag after soft reset", {23'h000000, flag}, 24'h000000);
        check("result cleared by soft reset", res, 24'h000000);
        $display("combining test done");
        os = 6'h01;
        for (p = 0; p < 2; p++) begin
            ss = (p == 0) ? 6'h00 : 6'h01;
            cs = (p == 0) ? 6'h01 : 6'h00;
            pulse(arm);
            repeat (30) @(posedge i_system_clock);
            pulse(arm);
            check("held busy", {23'h000000, busy}, 24'h000001);
            pulse(prst);
            check("busy after soft reset", {23'h000000, busy}, 24'h000000);
            check("result after soft reset", res, 24'h000000);
        end
        $display("sync and never test done");
        summarize();
    end
endmodule : testbench
`default_nettype wire
